// ===== verilog/mss_pkg.sv
/*
 * Shared constants, types and register map of the module system-services block.
 * Assumes a single 25 MHz core clock and an APB master with 32-bit data.
 */
`default_nettype none

package mss_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;
    localparam int REF_HZ = 5_000_000;
    localparam int REF_DIV = CLK_HZ / REF_HZ;
    localparam int RESET_MIN_MS = 100;
    localparam int POST_RESET_MS = 100;
    localparam int RESET_MIN_CYC = RESET_MIN_MS * (CLK_HZ / 1000);
    localparam int POST_RESET_CYC = POST_RESET_MS * (CLK_HZ / 1000);
    localparam int RATE_SLOW_MBPS = 10;
    localparam int RATE_FAST_MBPS = 20;
    localparam int RATE_UNIT_MBPS = 5;
    localparam int RATE_MOD = CLK_MHZ / RATE_UNIT_MBPS;
    localparam int RATE_SLOW_STEP = RATE_SLOW_MBPS / RATE_UNIT_MBPS;
    localparam int RATE_FAST_STEP = RATE_FAST_MBPS / RATE_UNIT_MBPS;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_INT_STAT = 12'h008;
    localparam logic [11:0] OFS_INT_MASK = 12'h00C;
    localparam logic [31:0] CTRL_RST = 32'h00000000;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam int CTRL_SOFT_FAULT = 0;
    localparam int EV_BOOT = 0;
    localparam int EV_FAULT = 1;
    localparam int EV_EARLY = 2;
    localparam int EV_SHORT = 3;
    localparam int EV_W = 4;
    localparam int NUM_LINKS = 4;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RESET = 3'h0,
        ST_WAIT = 3'h1,
        ST_READY = 3'h3,
        ST_RUN = 3'h2,
        ST_ANALYSE = 3'h6
    } mss_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } mss_apb_req_t;

endpackage

`default_nettype wire

// ===== verilog/mss_rate_tick.sv
/*
 * Bit-rate enable generator for one group of serial links.
 * Assumes the core clock is an integer multiple of the rate unit.
 */
`timescale 1ns/1ps
`default_nettype none

module mss_rate_tick #(
    parameter int MOD = mss_pkg::RATE_MOD,
    parameter int SLOW_STEP = mss_pkg::RATE_SLOW_STEP,
    parameter int FAST_STEP = mss_pkg::RATE_FAST_STEP
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic fast_in,
    output logic tick_out
);
    import mss_pkg::*;

    // A fractional accumulator gives the exact average rate; 10 Mbit/s is
    // not a whole divisor of the core clock, so edges jitter by one cycle.
    logic [7:0] acc_reg;
    logic [7:0] sum;

    always_comb begin
        sum = acc_reg + (fast_in ? 8'(FAST_STEP) : 8'(SLOW_STEP));
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            acc_reg <= 8'h00;
            tick_out <= 1'b0;
        end else if (sum >= 8'(MOD)) begin
            acc_reg <= sum - 8'(MOD);
            tick_out <= 1'b1;
        end else begin
            acc_reg <= sum;
            tick_out <= 1'b0;
        end
    end

endmodule // mss_rate_tick

`default_nettype wire

// ===== verilog/mss_top.sv
/*
 * System-services front end: reset sequencing, boot window, analyse mode,
 * link rate mapping, open-collector fault output and an APB register file.
 * Assumes all pins are synchronous to CORE_CLK_IN and that the wired fault
 * line is resolved outside and fed back on FAULT_LINE_IN.
 */
// Implementation choices: the APB interface to the registers and the placing of the registers.
// Functional notes
// R1: Link 0 follows the first rate select, links 1 to 3 follow the second.
// R2: A rate select at 0 gives 10 Mbit/s and at 1 gives 20 Mbit/s.
// R3: Host reset resets the processor and the rest of the module; the code keeps the register file and BOOT_LINK_OUT, which only RST_IN clears.
// R4: The host holds reset for at least 100 ms.
// R5: The host waits a further 100 ms after reset before using any link.
// R6: After the wait, the first link to deliver a boot packet is accepted.
// R7: Analyse with reset halts the processor and keeps its state.
// R8: In analyse mode interrogation is answered on any link.
// R9: The fault output is pulled low while the processor signals an error.
// R10: Up to ten fault outputs are wired; the line is low if any drives it.
// R11: A 5 MHz reference is derived and feeds the processor clocks.
// R12: During reset the link outputs idle and link input is ignored.
`timescale 1ns/1ps
`default_nettype none

module mss_top #(
    parameter int RESET_MIN = mss_pkg::RESET_MIN_CYC,
    parameter int POST_WAIT = mss_pkg::POST_RESET_CYC
) (
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    input wire mss_pkg::mss_apb_req_t APB_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    output logic IRQ_OUT,
    input wire logic HOST_RESET_IN,
    input wire logic ANALYSE_IN,
    input wire logic LINK0_RATE_SELECT_IN,
    input wire logic LINKS123_RATE_SELECT_IN,
    input wire logic CPU_ERROR_IN,
    input wire logic FAULT_LINE_IN,
    output logic FAULT_OUT_N_O_OUT,
    output logic FAULT_OUT_N_OE_OUT,
    input wire logic [3:0] SERIAL_RX_LINES_IN,
    input wire logic [3:0] CPU_TX_IN,
    output logic [3:0] SERIAL_TX_LINES_OUT,
    output logic [3:0] CPU_RX_OUT,
    output logic [3:0] LINK_BIT_EN_OUT,
    output logic REF_TICK_OUT,
    output logic CPU_RESET_OUT,
    output logic CPU_HALT_OUT,
    output logic BOOT_READY_OUT,
    output logic [1:0] BOOT_LINK_OUT
);
    import mss_pkg::*;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic [1:0] first_link(input logic [3:0] v);
        first_link = 2'h0;
        for (int i = NUM_LINKS - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_link = 2'(i);
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    mss_state_t state_reg, state_next;
    logic [31:0] wait_cnt_reg;
    logic [31:0] hold_cnt_reg;
    logic [2:0] ref_cnt_reg;
    logic host_rst_d_reg;
    logic [31:0] ctrl_reg;
    logic [EV_W-1:0] int_stat_reg, int_mask_reg, ev;
    logic links_open, fault_line_d_reg;
    logic tick_a, tick_b;
    logic wr, rd;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RESET: begin
                if (!HOST_RESET_IN) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (HOST_RESET_IN) begin
                    state_next = ST_RESET;
                end else if (wait_cnt_reg == 32'(POST_WAIT - 1)) begin
                    state_next = ST_READY; // R5
                end
            end
            ST_READY: begin
                if (HOST_RESET_IN) begin
                    state_next = ST_RESET;
                end else if (SERIAL_RX_LINES_IN != 4'h0) begin
                    state_next = ST_RUN; // R6
                end
            end
            ST_RUN: begin
                if (HOST_RESET_IN) begin
                    state_next = ANALYSE_IN ? ST_ANALYSE : ST_RESET; // R7 R3
                end
            end
            ST_ANALYSE: begin
                if (HOST_RESET_IN && !ANALYSE_IN) begin
                    state_next = ST_RESET;
                end
            end
            default: state_next = ST_RESET;
        endcase
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN || state_reg != ST_WAIT || HOST_RESET_IN) begin
            wait_cnt_reg <= 32'h00000000;
        end else begin
            wait_cnt_reg <= wait_cnt_reg + 32'h00000001;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            BOOT_LINK_OUT <= 2'h0;
        end else if (state_reg == ST_READY && !HOST_RESET_IN && SERIAL_RX_LINES_IN != 4'h0) begin
            BOOT_LINK_OUT <= first_link(SERIAL_RX_LINES_IN); // R6
        end
    end

    // Analyse keeps the processor out of reset so its state survives.
    assign CPU_RESET_OUT = (state_reg == ST_RESET); // R3
    assign CPU_HALT_OUT = (state_reg == ST_ANALYSE); // R7
    assign BOOT_READY_OUT = (state_reg == ST_READY);
    assign links_open = !HOST_RESET_IN && (state_reg == ST_READY || state_reg == ST_RUN ||
                                           state_reg == ST_ANALYSE); // R8

    // ------------------------------------------------------------------
    // Links and fault pin
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            SERIAL_TX_LINES_OUT <= 4'h0;
            CPU_RX_OUT <= 4'h0;
        end else begin
            SERIAL_TX_LINES_OUT <= links_open ? CPU_TX_IN : 4'h0; // R12
            CPU_RX_OUT <= links_open ? SERIAL_RX_LINES_IN : 4'h0; // R12
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            FAULT_OUT_N_OE_OUT <= 1'b0;
            fault_line_d_reg <= 1'b1;
        end else begin
            FAULT_OUT_N_OE_OUT <= CPU_ERROR_IN || ctrl_reg[CTRL_SOFT_FAULT]; // R9
            fault_line_d_reg <= FAULT_LINE_IN;
        end
    end

    // Open collector: the pin is only ever pulled low, never driven high.
    assign FAULT_OUT_N_O_OUT = 1'b0; // R10

    mss_rate_tick u_rate0 (
        .clk_in(CORE_CLK_IN),
        .rst_in(RST_IN),
        .fast_in(LINK0_RATE_SELECT_IN),
        .tick_out(tick_a)
    );

    mss_rate_tick u_rate123 (
        .clk_in(CORE_CLK_IN),
        .rst_in(RST_IN),
        .fast_in(LINKS123_RATE_SELECT_IN),
        .tick_out(tick_b)
    );

    assign LINK_BIT_EN_OUT = {tick_b, tick_b, tick_b, tick_a}; // R1 R2

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN || ref_cnt_reg == 3'(REF_DIV - 1)) begin
            ref_cnt_reg <= 3'h0;
        end else begin
            ref_cnt_reg <= ref_cnt_reg + 3'h1;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            REF_TICK_OUT <= 1'b0;
        end else begin
            REF_TICK_OUT <= (ref_cnt_reg == 3'(REF_DIV - 1)); // R11
        end
    end

    // ------------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            hold_cnt_reg <= 32'h00000000;
            host_rst_d_reg <= 1'b0;
        end else begin
            host_rst_d_reg <= HOST_RESET_IN;
            if (!HOST_RESET_IN) begin
                hold_cnt_reg <= 32'h00000000;
            end else if (hold_cnt_reg < 32'(RESET_MIN)) begin
                hold_cnt_reg <= hold_cnt_reg + 32'h00000001;
            end
        end
    end

    always_comb begin
        ev = '0;
        ev[EV_BOOT] = (state_reg == ST_READY) && (state_next == ST_RUN);
        ev[EV_FAULT] = fault_line_d_reg && !FAULT_LINE_IN; // R10
        ev[EV_EARLY] = (state_reg == ST_WAIT) && (SERIAL_RX_LINES_IN != 4'h0); // R5
        ev[EV_SHORT] = host_rst_d_reg && !HOST_RESET_IN &&
                       (hold_cnt_reg < 32'(RESET_MIN)); // R4
    end

    assign wr = APB_IN.psel && APB_IN.penable && APB_IN.pwrite;
    assign rd = APB_IN.psel && !APB_IN.pwrite;

    // A new event wins over a write-one-to-clear in the same cycle.
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            int_stat_reg <= '0;
        end else if (wr && APB_IN.paddr == OFS_INT_STAT) begin
            int_stat_reg <= (int_stat_reg & ~APB_IN.pwdata[EV_W-1:0]) | ev;
        end else begin
            int_stat_reg <= int_stat_reg | ev;
        end
    end

    assign IRQ_OUT = |(int_stat_reg & int_mask_reg);

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            ctrl_reg <= CTRL_RST;
            int_mask_reg <= MASK_RST;
        end else if (wr && APB_IN.paddr == OFS_CTRL) begin
            ctrl_reg <= {31'h00000000, APB_IN.pwdata[CTRL_SOFT_FAULT]};
        end else if (wr && APB_IN.paddr == OFS_INT_MASK) begin
            int_mask_reg <= APB_IN.pwdata[EV_W-1:0];
        end
    end

    always_comb begin
        PRDATA_OUT = 32'h00000000;
        if (rd) begin
            unique case (APB_IN.paddr)
                OFS_CTRL: PRDATA_OUT = ctrl_reg;
                OFS_STATUS: PRDATA_OUT = {20'h00000, FAULT_LINE_IN, LINKS123_RATE_SELECT_IN,
                                          LINK0_RATE_SELECT_IN, BOOT_LINK_OUT, 4'h0,
                                          state_reg};
                OFS_INT_STAT: PRDATA_OUT = {28'h0000000, int_stat_reg};
                OFS_INT_MASK: PRDATA_OUT = {28'h0000000, int_mask_reg};
                default: PRDATA_OUT = 32'h00000000;
            endcase
        end
    end

    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = APB_IN.psel && APB_IN.penable &&
                         !(APB_IN.paddr inside {OFS_CTRL, OFS_STATUS, OFS_INT_STAT, OFS_INT_MASK});

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_reset_held;
        HOST_RESET_IN [*2];
    endsequence

    sequence s_slow_gap;
        !tick_a ##1 tick_a;
    endsequence

    a_tx_idle_reset: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R12
        s_reset_held |-> SERIAL_TX_LINES_OUT == 4'h0 && CPU_RX_OUT == 4'h0)
        else $error("link active during reset");

    a_fault_follow: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R9
        CPU_ERROR_IN |=> FAULT_OUT_N_OE_OUT && !FAULT_OUT_N_O_OUT)
        else $error("fault pin not pulled low");

    a_wait_ends: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R5
        (state_reg == ST_WAIT && !HOST_RESET_IN && wait_cnt_reg == 32'(POST_WAIT - 1))
        |=> state_reg == ST_READY)
        else $error("boot window late");

    a_no_early_ready: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R5
        $rose(state_reg == ST_READY) |-> $past(wait_cnt_reg) == 32'(POST_WAIT - 1))
        else $error("boot window early");

    a_boot_pick: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R6
        (state_reg == ST_READY && !HOST_RESET_IN && SERIAL_RX_LINES_IN != 4'h0)
        |=> state_reg == ST_RUN && BOOT_LINK_OUT == first_link($past(SERIAL_RX_LINES_IN)))
        else $error("wrong boot link");

    a_analyse_entry: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R7
        (state_reg == ST_RUN && HOST_RESET_IN && ANALYSE_IN)
        |=> CPU_HALT_OUT && !CPU_RESET_OUT)
        else $error("analyse did not halt");

    a_reset_cpu: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R3
        (HOST_RESET_IN && !ANALYSE_IN) |=> CPU_RESET_OUT)
        else $error("processor not reset");

    a_slow_rate: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R2
        (!LINK0_RATE_SELECT_IN [*3] ##0 tick_a) |=> s_slow_gap or (!tick_a ##1 !tick_a))
        else $error("slow link ticks too often");

    a_fast_rate: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R1
        (LINKS123_RATE_SELECT_IN [*2] ##0 !tick_b) |=> tick_b)
        else $error("fast link tick missing");

    a_ref_period: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R11
        REF_TICK_OUT |=> !REF_TICK_OUT [*4] ##1 REF_TICK_OUT)
        else $error("reference period wrong");

    a_open_in_analyse: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R8
        (state_reg == ST_ANALYSE && !HOST_RESET_IN) |=> CPU_RX_OUT == $past(SERIAL_RX_LINES_IN))
        else $error("analyse link blocked");

endmodule // mss_top

`default_nettype wire

// ===== tb/mss_far_end.sv
/*
 * Far-side model: host controller and neighbouring modules of the block.
 * Assumes one shared clock and that the bench calls its tasks in sequence.
 */
`timescale 1ns/1ps
`default_nettype none

module mss_far_end (
    input wire logic clk_in,
    input wire logic fault_o_in,
    input wire logic fault_oe_in,
    input wire logic [8:0] peer_pull_in,
    output logic fault_line_out,
    output logic host_reset_out,
    output logic analyse_out,
    output logic [3:0] rx_out
);
    // ------------------------------------------------------------------
    // Wired fault line
    // ------------------------------------------------------------------
    // Nine peers plus this module make ten drivers on the line; a pull-up
    // holds it high when nobody sinks it.
    logic own_level;
    assign own_level = fault_oe_in ? fault_o_in : 1'b1;
    assign fault_line_out = own_level & ~(|peer_pull_in);

    // ------------------------------------------------------------------
    // Host pins
    // ------------------------------------------------------------------
    // Link inputs idle low, as their pull-downs would hold them.
    initial begin
        host_reset_out = 1'b1;
        analyse_out = 1'b0;
        rx_out = 4'h0;
    end

    task automatic reset_cycle(input int hold, input logic analyse);
        @(posedge clk_in);
        host_reset_out <= 1'b1;
        analyse_out <= analyse;
        repeat (hold) @(posedge clk_in);
        host_reset_out <= 1'b0;
    endtask

    // The bench only calls this after the quiet time, except where early
    // traffic is sent on purpose.
    task automatic send(input logic [3:0] bits);
        @(posedge clk_in);
        rx_out <= bits;
        @(posedge clk_in);
        rx_out <= 4'h0;
    endtask
endmodule // mss_far_end

`default_nettype wire

// ===== tb/module_system_services_tb.sv
/*
 * Self-checking bench of the system-services block over APB and its pins.
 * Assumes the design package and the far-side model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module module_system_services_tb;
    import mss_pkg::*;
    localparam int RESET_MIN = 20;
    localparam int POST_WAIT = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    mss_apb_req_t apb = '0;
    logic sel0 = 1'b0;
    logic sel123 = 1'b0;
    logic cpu_err = 1'b0;
    logic [3:0] cpu_tx = 4'h0;
    logic [8:0] peer = 9'h000;
    logic [31:0] prdata;
    logic pready, pslverr, irq, host_rst, analyse, fault_line, fault_o, fault_oe;
    logic ref_tick, cpu_reset, cpu_halt, boot_ready;
    logic [3:0] rx, tx, cpu_rx, bit_en;
    logic [1:0] boot_link;
    logic [31:0] rd_v;
    logic err;
    int cnt[4];
    int refs;
    int bad_count = 0;
    int checks_done = 0;

    always #20 clk = ~clk;

    mss_top #(.RESET_MIN(RESET_MIN), .POST_WAIT(POST_WAIT)) i_dut (
        .CORE_CLK_IN(clk), .RST_IN(rst), .APB_IN(apb), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .IRQ_OUT(irq),
        .HOST_RESET_IN(host_rst), .ANALYSE_IN(analyse),
        .LINK0_RATE_SELECT_IN(sel0), .LINKS123_RATE_SELECT_IN(sel123),
        .CPU_ERROR_IN(cpu_err), .FAULT_LINE_IN(fault_line),
        .FAULT_OUT_N_O_OUT(fault_o), .FAULT_OUT_N_OE_OUT(fault_oe),
        .SERIAL_RX_LINES_IN(rx), .CPU_TX_IN(cpu_tx), .SERIAL_TX_LINES_OUT(tx),
        .CPU_RX_OUT(cpu_rx), .LINK_BIT_EN_OUT(bit_en), .REF_TICK_OUT(ref_tick),
        .CPU_RESET_OUT(cpu_reset), .CPU_HALT_OUT(cpu_halt),
        .BOOT_READY_OUT(boot_ready), .BOOT_LINK_OUT(boot_link));

    mss_far_end i_far (
        .clk_in(clk), .fault_o_in(fault_o), .fault_oe_in(fault_oe),
        .peer_pull_in(peer), .fault_line_out(fault_line),
        .host_reset_out(host_rst), .analyse_out(analyse), .rx_out(rx));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // The master waits for pready itself; only the watchdog ends a hang.
    task automatic apb_xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                            output logic [31:0] rdata, output logic perr);
        @(posedge clk);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge clk);
        apb.penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdata = prdata;
        perr = pslverr;
        apb <= '0;
    endtask

    task automatic wr(input logic [11:0] addr, input logic [31:0] data);
        apb_xfer(1'b1, addr, data, rd_v, err);
        @(posedge clk);
    endtask

    task automatic reg_check(input string what, input logic [11:0] addr, input logic [31:0] exp);
        apb_xfer(1'b0, addr, 32'h00000000, rd_v, err);
        check(what, rd_v, exp);
    endtask

    function automatic logic [31:0] st(input logic [2:0] s, input logic [1:0] bl);
        return {20'h00000, 1'b1, sel123, sel0, bl, 4'h0, s};
    endfunction

    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("cpu_reset", {31'h0, cpu_reset}, 32'h1);
        reg_check("ctrl", OFS_CTRL, CTRL_RST);
        reg_check("mask", OFS_INT_MASK, {28'h0, MASK_RST});
        reg_check("status reset", OFS_STATUS, st(ST_RESET, 2'h0));
        cpu_tx <= 4'hA;
        i_far.reset_cycle(RESET_MIN + 5, 1'b0);
        repeat (3) @(posedge clk);
        reg_check("status wait", OFS_STATUS, st(ST_WAIT, 2'h0));
        check("tx in wait", {28'h0, tx}, 32'h0);
        i_far.send(4'h2);
        repeat (2) @(posedge clk);
        check("rx in wait", {28'h0, cpu_rx}, 32'h0);
        check("early ready", {31'h0, boot_ready}, 32'h0);
        repeat (POST_WAIT) @(posedge clk);
        check("boot ready", {31'h0, boot_ready}, 32'h1);
        i_far.send(4'hC);
        repeat (2) @(posedge clk);
        check("boot link", {30'h0, boot_link}, 32'h2);
        check("tx in run", {28'h0, tx}, 32'hA);
        reg_check("events boot", OFS_INT_STAT, 32'h5);
        reg_check("status run", OFS_STATUS, st(ST_RUN, 2'h2));
        // Twenty cycles hold whole periods of both rates, so phase drops out.
        for (int c = 0; c < 4; c++) begin
            sel0 <= c[0];
            sel123 <= c[1];
            repeat (6) @(posedge clk);
            cnt = '{0, 0, 0, 0};
            refs = 0;
            repeat (20) begin
                @(posedge clk);
                for (int k = 0; k < 4; k++) cnt[k] += int'(bit_en[k] === 1'b1);
                refs += int'(ref_tick === 1'b1);
            end
            check("rate link0", cnt[0], 20 * (c[0] ? RATE_FAST_STEP : RATE_SLOW_STEP) / RATE_MOD);
            for (int k = 1; k < 4; k++)
                check("rate links123", cnt[k], 20 * (c[1] ? RATE_FAST_STEP : RATE_SLOW_STEP) / RATE_MOD);
            check("ref ticks", refs, 20 / REF_DIV);
            reg_check("status rates", OFS_STATUS, st(ST_RUN, 2'h2));
        end
        check("irq idle", {31'h0, irq}, 32'h0);
        wr(OFS_INT_MASK, 32'h1);
        check("irq masked in", {31'h0, irq}, 32'h1);
        wr(OFS_INT_STAT, 32'h1);
        check("irq cleared", {31'h0, irq}, 32'h0);
        reg_check("events left", OFS_INT_STAT, 32'h4);
        wr(OFS_INT_MASK, 32'hF);
        check("irq other", {31'h0, irq}, 32'h1);
        wr(OFS_INT_STAT, 32'h4);
        check("irq none", {31'h0, irq}, 32'h0);
        wr(12'h010, 32'h1);
        apb_xfer(1'b0, 12'h010, 32'h0, rd_v, err);
        check("unmapped err", {31'h0, err}, 32'h1);
        check("unmapped data", rd_v, 32'h0);
        reg_check("ctrl kept", OFS_CTRL, 32'h0);
        check("mapped err", {31'h0, err}, 32'h0);
        cpu_err <= 1'b1;
        repeat (2) @(posedge clk);
        check("fault pull", {30'h0, fault_oe, fault_o}, 32'h2);
        check("fault line", {31'h0, fault_line}, 32'h0);
        cpu_err <= 1'b0;
        repeat (2) @(posedge clk);
        check("fault free", {30'h0, fault_oe, fault_line}, 32'h1);
        peer <= 9'h100;
        repeat (2) @(posedge clk);
        check("peer fault", {30'h0, fault_oe, fault_line}, 32'h0);
        peer <= 9'h000;
        wr(OFS_CTRL, 32'h1);
        @(posedge clk);
        check("soft fault", {31'h0, fault_oe}, 32'h1);
        wr(OFS_CTRL, 32'h0);
        reg_check("fault event", OFS_INT_STAT, 32'h2);
        wr(OFS_INT_STAT, 32'h2);
        i_far.reset_cycle(2, 1'b1);
        repeat (2) @(posedge clk);
        check("halt", {30'h0, cpu_halt, cpu_reset}, 32'h2);
        check("kept link", {30'h0, boot_link}, 32'h2);
        reg_check("status analyse", OFS_STATUS, st(ST_ANALYSE, 2'h2));
        i_far.send(4'h8);
        @(posedge clk);
        check("interrogate", {28'h0, cpu_rx}, 32'h8);
        wr(OFS_INT_STAT, 32'h8);
        reg_check("short cleared", OFS_INT_STAT, 32'h0);
        i_far.reset_cycle(3, 1'b0);
        reg_check("short reset", OFS_INT_STAT, 32'h8);
        tally_and_finish();
    end
endmodule // module_system_services_tb

`default_nettype wire
